/* design/wwmc_pkg.sv */
package wwmc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int          CLK_HZ      = 125_000_000;
  localparam int          LF_OSC_HZ   = 31_000;
  localparam int          MF_OSC_HZ   = 31_250;
  localparam int          BASE_MS     = 1;
  localparam int          LF_DIV      = CLK_HZ / LF_OSC_HZ;
  localparam int          MF_DIV      = CLK_HZ / MF_OSC_HZ;
  // osc ticks per base interval, rounded down
  localparam int          BASE_TICKS  = LF_OSC_HZ * BASE_MS / 1000;
  // 2^18 base intervals is the 256 s nominal ceiling
  localparam logic [4:0]  MAX_LOG2    = 5'h12;
  localparam int          CNT_W       = 19;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0]  OFS_CFG     = 8'h00;
  localparam logic [7:0]  OFS_CTRL_A  = 8'h04;
  localparam logic [7:0]  OFS_CTRL_B  = 8'h08;
  localparam logic [7:0]  OFS_CLEAR   = 8'h0c;
  localparam logic [7:0]  OFS_STATE   = 8'h10;
  localparam logic [7:0]  OFS_COUNT   = 8'h14;
  localparam logic [7:0]  OFS_ISTAT   = 8'h18;
  localparam logic [7:0]  OFS_ICLR    = 8'h1c;
  localparam logic [7:0]  OFS_IEN     = 8'h20;

  ////////////////////////////////////////////////////////////////////////////
  // fields and reset values
  localparam int          CFG_W       = 10;
  localparam int          CTRL_A_W    = 6;
  localparam int          CTRL_B_W    = 3;
  localparam int          EV_W        = 2;
  localparam int          EV_TIMEOUT  = 0;
  localparam int          EV_RUNCHG   = 1;
  localparam logic [2:0]  CS_LF       = 3'h0;
  localparam logic [2:0]  CS_MF       = 3'h1;
  localparam logic [4:0]  PS_SOFT     = 5'h1f;
  localparam logic [2:0]  CFG_CS_RST  = 3'h7;
  localparam logic [4:0]  CFG_PS_RST  = 5'h1f;
  // 2^11 base intervals, the nominal 2 s default
  localparam logic [4:0]  CTRLA_PS_RST = 5'h0b;
  localparam logic [2:0]  CTRLB_CS_RST = 3'h0;

  typedef enum logic [1:0] {
    MODE_OFF     = 2'b00,
    MODE_SOFT    = 2'b01,
    MODE_NOSLEEP = 2'b10,
    MODE_ALWAYS  = 2'b11
  } wwmc_mode_e;

  typedef struct packed {
    logic [4:0] cfg_period_prescale;
    logic [2:0] cfg_clock_select;
    wwmc_mode_e monitor_enable_cfg;
  } wwmc_cfg_s;

  typedef struct packed {
    logic [4:0] period_prescale_sel;
    logic       software_run_bit;
  } wwmc_ctrl_a_s;

  localparam wwmc_cfg_s    CFG_RST    = '{CFG_PS_RST, CFG_CS_RST, MODE_ALWAYS};
  localparam wwmc_ctrl_a_s CTRL_A_RST = '{CTRLA_PS_RST, 1'b0};

endpackage

/* design/wwmc_div.sv */
`timescale 1ns/1ps
// free divider: tick is high in the enabled cycle that completes DIV counts
module wwmc_div #(
  parameter int DIV = 4
) (
  input  wire logic clk,    // system clock
  input  wire logic rst_n,  // sync reset, active low
  input  wire logic en,     // count enable
  input  wire logic clr,    // restart the count
  output logic      tick    // one-cycle pulse
);

  localparam logic [11:0] LAST = 12'(DIV - 1);

  logic [11:0] cnt_ff;

  assign tick = en && !clr && (cnt_ff == LAST);

  always_ff @(posedge clk) begin
    if (!rst_n || clr) begin
      cnt_ff <= 12'h000;
    end else if (en) begin
      cnt_ff <= (cnt_ff == LAST) ? 12'h000 : 12'(cnt_ff + 12'h001);
    end
  end

endmodule

/* design/wwmc_tmo.sv */
`timescale 1ns/1ps
// time-out counter in base intervals; expire pulses when 2^limit_log2 is reached
module wwmc_tmo (
  input  wire logic                       clk,         // system clock
  input  wire logic                       rst_n,       // sync reset, active low
  input  wire logic                       tick,        // one base interval
  input  wire logic                       clr,         // clear the count
  input  wire logic [4:0]                 limit_log2,  // period exponent
  output logic [wwmc_pkg::CNT_W-1:0]      count,       // intervals elapsed
  output logic                            expire       // one-cycle pulse
);

  logic [wwmc_pkg::CNT_W-1:0] cnt_ff;
  logic                       exp_ff;
  logic [wwmc_pkg::CNT_W-1:0] last;

  assign last   = wwmc_pkg::CNT_W'((wwmc_pkg::CNT_W'(1) << limit_log2) - wwmc_pkg::CNT_W'(1));
  assign count  = cnt_ff;
  assign expire = exp_ff;

  always_ff @(posedge clk) begin
    if (!rst_n || clr) begin
      cnt_ff <= '0;
      exp_ff <= 1'b0;
    end else if (tick && cnt_ff >= last) begin
      cnt_ff <= '0;
      exp_ff <= 1'b1;
    end else begin
      cnt_ff <= tick ? wwmc_pkg::CNT_W'(cnt_ff + 1'b1) : cnt_ff;
      exp_ff <= 1'b0;
    end
  end

endmodule

/* design/wwmc_top.sv */
// Operation
// - time base comes from the 31 kHz or the 31.25 kHz oscillator.
// - enable field upper bit set: configuration clock-select field picks the source.
// - enable field 01: software run bit runs it, control-B select picks source.
// - every period is a power-of-two multiple of a 1 ms base interval.
// - exactly four modes, chosen only by the two-bit enable configuration field.
// - enable field 11: always running, also in sleep, run bit ignored.
// - enable field 10: running while awake, stopped while in sleep.
// - enable field 01: run state follows run bit, sleep leaves it unchanged.
// - configuration prescale all ones: control-A prescale sets 1 ms to 256 s.
// - after reset the time-out period defaults to nominal 2 s.
`timescale 1ns/1ps
module wwmc_top (
  input  wire logic        CLK,              // 125 MHz clock
  input  wire logic        RST_N,            // sync reset, active low
  input  wire logic [7:0]  AVS_ADDRESS,      // byte address
  input  wire logic        AVS_READ,         // read request
  input  wire logic        AVS_WRITE,        // write request
  input  wire logic [31:0] AVS_WRITEDATA,    // write data
  input  wire logic [3:0]  AVS_BYTEENABLE,   // write byte lanes
  output logic      [31:0] AVS_READDATA,     // read data
  output logic             AVS_WAITREQUEST,  // stall
  input  wire logic        SLEEP,            // device is in sleep
  output logic             WDT_RESET,        // time-out reset pulse
  output logic             RUNNING,          // monitor active
  output logic             IRQ               // level interrupt
);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [4:0] clamp_ps(input logic [4:0] ps);
    return (ps > wwmc_pkg::MAX_LOG2) ? wwmc_pkg::MAX_LOG2 : ps;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus slave: one wait cycle, access completes in the cycle waitrequest is low

  logic                           wait_ff;
  logic [31:0]                    rdata_ff;
  logic [31:0]                    nxt_rdata;
  logic                           req;
  logic                           wr_acc;
  wwmc_pkg::wwmc_cfg_s            cfg_ff;
  wwmc_pkg::wwmc_ctrl_a_s         ctrl_a_ff;
  logic [wwmc_pkg::CTRL_B_W-1:0]  ctrl_b_ff;
  logic [wwmc_pkg::EV_W-1:0]      istat_ff;
  logic [wwmc_pkg::EV_W-1:0]      ien_ff;
  logic [wwmc_pkg::EV_W-1:0]      events;
  logic [wwmc_pkg::CNT_W-1:0]     tmo_count;
  logic                           run_ff;
  logic                           nxt_run;
  logic                           sleep_d_ff;
  logic                           src_mf;
  logic                           wdt_rst_ff;
  logic                           irq_ff;

  assign req    = AVS_READ || AVS_WRITE;
  assign wr_acc = AVS_WRITE && !wait_ff;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wait_ff <= 1'b1;
    end else begin
      wait_ff <= !(req && wait_ff);
    end
  end

  always_comb begin
    nxt_rdata = 32'h0000_0000;
    case (AVS_ADDRESS)
      wwmc_pkg::OFS_CFG:    nxt_rdata[wwmc_pkg::CFG_W-1:0] = cfg_ff;
      wwmc_pkg::OFS_CTRL_A: nxt_rdata[wwmc_pkg::CTRL_A_W-1:0] = ctrl_a_ff;
      wwmc_pkg::OFS_CTRL_B: nxt_rdata[wwmc_pkg::CTRL_B_W-1:0] = ctrl_b_ff;
      wwmc_pkg::OFS_STATE:  nxt_rdata[2:0] = {src_mf, sleep_d_ff, run_ff};
      wwmc_pkg::OFS_COUNT:  nxt_rdata[wwmc_pkg::CNT_W-1:0] = tmo_count;
      wwmc_pkg::OFS_ISTAT:  nxt_rdata[wwmc_pkg::EV_W-1:0] = istat_ff;
      wwmc_pkg::OFS_IEN:    nxt_rdata[wwmc_pkg::EV_W-1:0] = ien_ff;
      // clear and interrupt-clear are write-only, unmapped reads give zero
      default:              nxt_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rdata_ff <= 32'h0000_0000;
    end else if (AVS_READ && wait_ff) begin
      rdata_ff <= nxt_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration and control registers

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      cfg_ff <= wwmc_pkg::CFG_RST;
    end else if (wr_acc && AVS_ADDRESS == wwmc_pkg::OFS_CFG) begin
      cfg_ff <= wwmc_pkg::CFG_W'(be_merge(32'(cfg_ff), AVS_WRITEDATA, AVS_BYTEENABLE));
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ctrl_a_ff <= wwmc_pkg::CTRL_A_RST;
    end else if (wr_acc && AVS_ADDRESS == wwmc_pkg::OFS_CTRL_A) begin
      ctrl_a_ff <= wwmc_pkg::CTRL_A_W'(be_merge(32'(ctrl_a_ff), AVS_WRITEDATA, AVS_BYTEENABLE));
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ctrl_b_ff <= wwmc_pkg::CTRLB_CS_RST;
    end else if (wr_acc && AVS_ADDRESS == wwmc_pkg::OFS_CTRL_B) begin
      ctrl_b_ff <= wwmc_pkg::CTRL_B_W'(be_merge(32'(ctrl_b_ff), AVS_WRITEDATA, AVS_BYTEENABLE));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // mode decode

  wwmc_pkg::wwmc_mode_e mode;
  logic                 sleep_rise;
  logic                 tmo_clr;
  logic [4:0]           eff_ps;

  assign mode       = cfg_ff.monitor_enable_cfg;
  assign sleep_rise = SLEEP && !sleep_d_ff;

  always_comb begin
    case (mode)
      wwmc_pkg::MODE_ALWAYS:  nxt_run = 1'b1;
      wwmc_pkg::MODE_NOSLEEP: nxt_run = !SLEEP;
      wwmc_pkg::MODE_SOFT:    nxt_run = ctrl_a_ff.software_run_bit;
      wwmc_pkg::MODE_OFF:     nxt_run = 1'b0;
      default:                nxt_run = 1'b0;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      run_ff     <= 1'b0;
      sleep_d_ff <= 1'b0;
    end else begin
      run_ff     <= nxt_run;
      sleep_d_ff <= SLEEP;
    end
  end

  // upper enable bit: configuration select, else control-B select
  assign src_mf = mode[1] ? (cfg_ff.cfg_clock_select == wwmc_pkg::CS_MF)
                          : (ctrl_b_ff == wwmc_pkg::CS_MF);

  // a prescale other than all ones in the configuration overrides software
  assign eff_ps = (cfg_ff.cfg_period_prescale == wwmc_pkg::PS_SOFT)
                  ? clamp_ps(ctrl_a_ff.period_prescale_sel)
                  : clamp_ps(cfg_ff.cfg_period_prescale);

  ////////////////////////////////////////////////////////////////////////////
  // time base and time-out

  logic lf_tick;
  logic mf_tick;
  logic osc_tick;
  logic ms_tick;
  logic tmo_expire;
  logic ctl_write;

  assign ctl_write = wr_acc && (AVS_ADDRESS == wwmc_pkg::OFS_CTRL_A ||
                                AVS_ADDRESS == wwmc_pkg::OFS_CTRL_B ||
                                AVS_ADDRESS == wwmc_pkg::OFS_CLEAR);
  // stopping, sleep entry or any control write restarts the period
  assign tmo_clr = !run_ff || sleep_rise || ctl_write;

  // only the selected oscillator runs, and only while monitoring
  wwmc_div #(.DIV(wwmc_pkg::LF_DIV)) u_lf_osc (
    .clk   (CLK),
    .rst_n (RST_N),
    .en    (run_ff && !src_mf),
    .clr   (1'b0),
    .tick  (lf_tick)
  );

  wwmc_div #(.DIV(wwmc_pkg::MF_DIV)) u_mf_osc (
    .clk   (CLK),
    .rst_n (RST_N),
    .en    (run_ff && src_mf),
    .clr   (1'b0),
    .tick  (mf_tick)
  );

  assign osc_tick = src_mf ? mf_tick : lf_tick;

  // 1 ms base interval from the oscillator ticks
  wwmc_div #(.DIV(wwmc_pkg::BASE_TICKS)) u_base (
    .clk   (CLK),
    .rst_n (RST_N),
    .en    (osc_tick),
    .clr   (tmo_clr),
    .tick  (ms_tick)
  );

  wwmc_tmo u_tmo (
    .clk        (CLK),
    .rst_n      (RST_N),
    .tick       (ms_tick),
    .clr        (tmo_clr),
    .limit_log2 (eff_ps),
    .count      (tmo_count),
    .expire     (tmo_expire)
  );

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      wdt_rst_ff <= 1'b0;
    end else begin
      wdt_rst_ff <= tmo_expire && run_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupts: a new event wins over a clear in the same cycle

  logic [wwmc_pkg::EV_W-1:0] iclr;

  assign events[wwmc_pkg::EV_TIMEOUT] = tmo_expire && run_ff;
  assign events[wwmc_pkg::EV_RUNCHG]  = nxt_run != run_ff;
  assign iclr = (wr_acc && AVS_ADDRESS == wwmc_pkg::OFS_ICLR && AVS_BYTEENABLE[0])
                ? AVS_WRITEDATA[wwmc_pkg::EV_W-1:0] : '0;

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      istat_ff <= '0;
    end else begin
      istat_ff <= (istat_ff & ~iclr) | events;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ien_ff <= '0;
    end else if (wr_acc && AVS_ADDRESS == wwmc_pkg::OFS_IEN && AVS_BYTEENABLE[0]) begin
      ien_ff <= AVS_WRITEDATA[wwmc_pkg::EV_W-1:0];
    end
  end

  // registered from next state so irq tracks istat with no extra lag
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(((istat_ff & ~iclr) | events) & ien_ff);
    end
  end

  assign AVS_READDATA    = rdata_ff;
  assign AVS_WAITREQUEST = wait_ff;
  assign WDT_RESET       = wdt_rst_ff;
  assign RUNNING         = run_ff;
  assign IRQ             = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_off_stopped;
    mode == wwmc_pkg::MODE_OFF |=> !RUNNING && !WDT_RESET;
  endproperty
  a_off_stopped: assert property (p_off_stopped) else $error("runs in off mode");

  property p_always_runs;
    // the edge that releases reset still holds run low, so it is no trigger
    RST_N && mode == wwmc_pkg::MODE_ALWAYS |=> RUNNING;
  endproperty
  a_always_runs: assert property (p_always_runs) else $error("stopped in always mode");

  property p_nosleep;
    mode == wwmc_pkg::MODE_NOSLEEP |=> RUNNING == !$past(SLEEP);
  endproperty
  a_nosleep: assert property (p_nosleep) else $error("sleep gating wrong");

  property p_soft_follows;
    mode == wwmc_pkg::MODE_SOFT |=> RUNNING == $past(ctrl_a_ff.software_run_bit);
  endproperty
  a_soft_follows: assert property (p_soft_follows) else $error("run bit not followed");

  property p_timeout_reset;
    run_ff && tmo_expire |=> WDT_RESET ##1 !WDT_RESET;
  endproperty
  a_timeout_reset: assert property (p_timeout_reset) else $error("no reset on time-out");

  property p_idle_quiet;
    !run_ff [*2] |=> !tmo_expire && tmo_count == '0;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("counter moves while stopped");

  property p_src_cfg;
    mode[1] && cfg_ff.cfg_clock_select == wwmc_pkg::CS_LF |-> !mf_tick;
  endproperty
  a_src_cfg: assert property (p_src_cfg) else $error("wrong oscillator");

  property p_src_soft;
    mode == wwmc_pkg::MODE_SOFT && ctrl_b_ff == wwmc_pkg::CS_MF |-> !lf_tick;
  endproperty
  a_src_soft: assert property (p_src_soft) else $error("control-B select ignored");

  property p_base_on_osc;
    ms_tick |-> (lf_tick || mf_tick);
  endproperty
  a_base_on_osc: assert property (p_base_on_osc) else $error("base interval off oscillator");

  property p_soft_period;
    cfg_ff.cfg_period_prescale == wwmc_pkg::PS_SOFT && ctrl_a_ff.period_prescale_sel <= wwmc_pkg::MAX_LOG2
      |-> eff_ps == ctrl_a_ff.period_prescale_sel;
  endproperty
  a_soft_period: assert property (p_soft_period) else $error("prescale select ignored");

  property p_reset_period;
    !$past(RST_N) |-> ctrl_a_ff.period_prescale_sel == wwmc_pkg::CTRLA_PS_RST;
  endproperty
  a_reset_period: assert property (@(posedge CLK) p_reset_period) else $error("bad default period");

  property p_one_wait;
    req && AVS_WAITREQUEST |=> !AVS_WAITREQUEST ##1 AVS_WAITREQUEST;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("waitrequest timing");

  c_timeout:   cover property (run_ff && tmo_expire ##1 WDT_RESET);
  c_nosleep:   cover property (mode == wwmc_pkg::MODE_NOSLEEP && RUNNING ##1 SLEEP ##1 !RUNNING);
  c_soft_on:   cover property (mode == wwmc_pkg::MODE_SOFT && !RUNNING ##1 RUNNING);
  c_irq:       cover property (!IRQ ##1 IRQ);

endmodule

/* dv/wwmc_tb.sv */
`timescale 1ns/1ps
module wwmc_tb;

  logic        clk;
  logic        rst_n;
  logic [7:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        sleep;
  logic        wdt_reset;
  logic        running;
  logic        irq;
  int          error_cnt;
  int          n_compared;
  int          cyc_cnt;

  wwmc_top dut_u (
    .CLK             (clk),
    .RST_N           (rst_n),
    .AVS_ADDRESS     (avs_address),
    .AVS_READ        (avs_read),
    .AVS_WRITE       (avs_write),
    .AVS_WRITEDATA   (avs_writedata),
    .AVS_BYTEENABLE  (avs_byteenable),
    .AVS_READDATA    (avs_readdata),
    .AVS_WAITREQUEST (avs_waitrequest),
    .SLEEP           (sleep),
    .WDT_RESET       (wdt_reset),
    .RUNNING         (running),
    .IRQ             (irq)
  );

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
  end

  always #4 clk = ~clk;

  // one timed period is ~124k cycles, so the ceiling sits well above that
  always @(posedge clk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 200000) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH run length expected below 200000 cycles, seen %0d", cyc_cnt);
      wrap_up();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      error_cnt = error_cnt + 1;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // request held until waitrequest is sampled low at a rising edge; data taken at that edge
  // no wait count is assumed: a hung slave is caught by the cycle ceiling
  task automatic bus(input logic is_wr, input logic [7:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata);
    @(posedge clk);
    avs_address   <= addr;
    avs_writedata <= wdata;
    avs_read      <= ~is_wr;
    avs_write     <= is_wr;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] addr, input logic [31:0] wdata);
    logic [31:0] dummy;
    bus(1'b1, addr, wdata, dummy);
  endtask

  task automatic rd_chk(input string what, input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] got;
    bus(1'b0, addr, 32'h0000_0000, got);
    check(what, exp, got);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [1:0]  m;
    logic        s;
    logic        r;
    logic        exp_run;
    int          n;
    rst_n          = 1'b0;
    avs_address    = 8'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'hf;
    sleep          = 1'b0;
    error_cnt      = 0;
    n_compared     = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    settle(2);

    // reset values, default 2 s period and always-on mode
    check("RUNNING after reset", 32'h1, {31'h0, running});
    rd_chk("CFG reset", wwmc_pkg::OFS_CFG, 32'h0000_03ff);
    rd_chk("CTRL_A reset", wwmc_pkg::OFS_CTRL_A, 32'h0000_0016);
    rd_chk("CTRL_B reset", wwmc_pkg::OFS_CTRL_B, 32'h0000_0000);
    rd_chk("unmapped read", 8'h40, 32'h0000_0000);
    wr(wwmc_pkg::OFS_ISTAT, 32'h0000_0000);
    rd_chk("ISTAT after reset", wwmc_pkg::OFS_ISTAT, 32'h0000_0002);
    $display("test reset done");

    // every mode against every sleep and run bit combination
    for (int i = 0; i < 16; i++) begin
      {m, s, r} = i[3:0];
      wr(wwmc_pkg::OFS_CFG, {22'h0, 5'h1f, 3'h7, m});
      wr(wwmc_pkg::OFS_CTRL_A, {26'h0, 5'h0b, r});
      @(posedge clk);
      sleep <= s;
      settle(3);
      case (m)
        2'b11:   exp_run = 1'b1;
        2'b10:   exp_run = ~s;
        2'b01:   exp_run = r;
        default: exp_run = 1'b0;
      endcase
      check($sformatf("RUNNING mode %b sleep %b run %b", m, s, r), {31'h0, exp_run}, {31'h0, running});
    end
    @(posedge clk);
    sleep <= 1'b0;
    $display("test modes done");

    // source follows the config select in modes 1x, the control-B select in 01
    wr(wwmc_pkg::OFS_CTRL_B, 32'h0000_0000);
    wr(wwmc_pkg::OFS_CFG, 32'h0000_03e7);
    settle(2);
    rd_chk("STATE cfg mid osc", wwmc_pkg::OFS_STATE, 32'h0000_0005);
    wr(wwmc_pkg::OFS_CFG, 32'h0000_03e2);
    settle(2);
    rd_chk("STATE cfg low osc", wwmc_pkg::OFS_STATE, 32'h0000_0001);
    wr(wwmc_pkg::OFS_CFG, 32'h0000_03e5);
    wr(wwmc_pkg::OFS_CTRL_A, 32'h0000_0017);
    settle(2);
    rd_chk("STATE soft low osc", wwmc_pkg::OFS_STATE, 32'h0000_0001);
    wr(wwmc_pkg::OFS_CTRL_B, 32'h0000_0001);
    settle(2);
    rd_chk("STATE soft mid osc", wwmc_pkg::OFS_STATE, 32'h0000_0005);
    $display("test clock select done");

    // run change event: enabled, cleared, then masked
    wr(wwmc_pkg::OFS_IEN, 32'h0000_0002);
    settle(2);
    check("IRQ enabled event", 32'h1, {31'h0, irq});
    wr(wwmc_pkg::OFS_ICLR, 32'h0000_0003);
    settle(2);
    check("IRQ after clear", 32'h0, {31'h0, irq});
    rd_chk("ISTAT after clear", wwmc_pkg::OFS_ISTAT, 32'h0000_0000);
    wr(wwmc_pkg::OFS_IEN, 32'h0000_0000);
    wr(wwmc_pkg::OFS_CTRL_A, 32'h0000_0016);
    settle(2);
    check("RUNNING run bit low", 32'h0, {31'h0, running});
    check("IRQ masked", 32'h0, {31'h0, irq});
    rd_chk("ISTAT masked event", wwmc_pkg::OFS_ISTAT, 32'h0000_0002);
    rd_chk("IEN readback", wwmc_pkg::OFS_IEN, 32'h0000_0000);
    wr(wwmc_pkg::OFS_ICLR, 32'h0000_0003);
    $display("test interrupts done");

    // 1 ms period on the 31.25 kHz source: 31 ticks of 4000 cycles
    wr(wwmc_pkg::OFS_CFG, 32'h0000_03e7);
    wr(wwmc_pkg::OFS_ICLR, 32'h0000_0003);
    wr(wwmc_pkg::OFS_IEN, 32'h0000_0001);
    wr(wwmc_pkg::OFS_CTRL_A, 32'h0000_0000);
    n = 0;
    while (wdt_reset !== 1'b1 && n < 130000) begin
      @(negedge clk);
      n = n + 1;
    end
    // the oscillator divider phase at the restart is not pinned, so allow one tick early
    check("reset pulse seen", 32'h1, {31'h0, wdt_reset});
    check("period not early", 32'h1, {31'h0, (n >= 120000)});
    check("period not late", 32'h1, {31'h0, (n <= 124100)});
    settle(1);
    check("reset pulse width", 32'h0, {31'h0, wdt_reset});
    check("IRQ on time-out", 32'h1, {31'h0, irq});
    rd_chk("ISTAT time-out", wwmc_pkg::OFS_ISTAT, 32'h0000_0001);
    wr(wwmc_pkg::OFS_ICLR, 32'h0000_0001);
    settle(2);
    check("IRQ after time-out clear", 32'h0, {31'h0, irq});
    $display("test time-out done");

    wrap_up();
  end

endmodule
